// File: rtl/srcirq_cfg.svh
// Register offsets, field positions, reset values and timing counts of the interrupt block
`ifndef SRCIRQ_CFG_SVH
`define SRCIRQ_CFG_SVH

// ---------------------------------------------------------------
// Register map (16-bit words, high byte at the even address)
// ---------------------------------------------------------------
`define SRCIRQ_CTRL_ADDR      8'h10
`define SRCIRQ_SRC_EN_ADDR    8'h12
`define SRCIRQ_SRC_STA_ADDR   8'h14
`define SRCIRQ_PIN_EN_ADDR    8'h16
`define SRCIRQ_PIN_STA_ADDR   8'h18

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SRCIRQ_CTRL_GATE_BIT  0
`define SRCIRQ_CTRL_TYPE_BIT  1
`define SRCIRQ_CTRL_POL_BIT   2
`define SRCIRQ_SRC_WAKE_BIT   0
`define SRCIRQ_SRC_KP_BIT     1
`define SRCIRQ_SRC_OVF_BIT    2
`define SRCIRQ_SRC_RSVD_BIT   3
`define SRCIRQ_SRC_PWM_LSB    4
`define SRCIRQ_SRC_GPIO_BIT   8

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SRCIRQ_CTRL_RST       3'h0
`define SRCIRQ_SRC_RST        9'h000
`define SRCIRQ_PIN_RST        16'h0000
`define SRCIRQ_OUT_RST        1'b1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SRCIRQ_CLK_PERIOD_PS  5000
`define SRCIRQ_PULSE_NS       250
`define SRCIRQ_PULSE_CYC      ((`SRCIRQ_PULSE_NS * 1000) / `SRCIRQ_CLK_PERIOD_PS)

`endif

// File: rtl/srcirq_pkg.sv
// Types shared by the interrupt status block and its output shaper
package srcirq_pkg;

    // Byte register access from the serial front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } srcirq_bus_s;

    // Internal source event pulses
    typedef struct packed {
        logic [3:0] pwm;
        logic       kp_ovf;
        logic       kp;
        logic       wake;
    } srcirq_evt_s;

    // Register state of the main block
    typedef struct packed {
        logic [2:0]  ctrl;
        logic [8:0]  src_en;
        logic [8:0]  src_sta;
        logic [15:0] pin_en;
        logic [15:0] pin_sta;
        logic [7:0]  rdata;
    } srcirq_state_s;

    // Output shaper states
    typedef enum logic [2:0] {
        SHP_IDLE  = 3'b001,
        SHP_PULSE = 3'b010,
        SHP_HOLD  = 3'b100
    } srcirq_shp_e;

    typedef struct packed {
        srcirq_shp_e st;
        logic [7:0]  cnt;
        logic        out;
    } srcirq_shp_s;

endpackage

// File: rtl/srcirq_shaper.sv
// Host interrupt pin shaper: level or fixed-width pulse, selectable polarity
`timescale 1ns/1ps
`include "srcirq_cfg.svh"

module srcirq_shaper
    import srcirq_pkg::*;
#(
    parameter int PULSE_CYC = `SRCIRQ_PULSE_CYC
)
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Configuration and request
    input  wire logic pending,
    input  wire logic edge_mode,
    input  wire logic active_high,
    // Pin level
    output logic      irq_out
);

    srcirq_shp_s s_reg;
    srcirq_shp_s s_next;
    logic        active_next;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    // Edge mode rearms only after pending drops, so one cause gives one pulse
    always_comb
    begin
        s_next = s_reg;
        unique case (s_reg.st)
            SHP_IDLE:
            begin
                s_next.cnt = 8'h00;
                if (edge_mode && pending)
                begin
                    s_next.st = SHP_PULSE;
                end
            end
            SHP_PULSE:
            begin
                s_next.cnt = s_reg.cnt + 8'h01;
                if (s_reg.cnt == 8'(PULSE_CYC - 1))
                begin
                    s_next.st = SHP_HOLD;
                end
            end
            SHP_HOLD:
            begin
                if (!pending)
                begin
                    s_next.st = SHP_IDLE;
                end
            end
            default:
            begin
                s_next.st = SHP_IDLE;
            end
        endcase
        if (!edge_mode)
        begin
            s_next.st  = SHP_IDLE;
            s_next.cnt = 8'h00;
        end
        active_next = edge_mode ? (s_next.st == SHP_PULSE) : pending;
        s_next.out  = active_high ? active_next : ~active_next;
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_reg.st  <= SHP_IDLE;
            s_reg.cnt <= 8'h00;
            s_reg.out <= `SRCIRQ_OUT_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign irq_out = s_reg.out;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_pulse_len;
        s_reg.st == SHP_PULSE |-> s_reg.cnt < 8'(PULSE_CYC);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse too long");

    property p_pulse_ends;
        (edge_mode && $rose(s_reg.st == SHP_PULSE)) |-> ##[1:60] (s_reg.st != SHP_PULSE);
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("pulse never ends");

    property p_level_follow;
        (!edge_mode && pending && active_high) |=> irq_out;
    endproperty
    a_level_follow: assert property (p_level_follow) else $error("level irq missing");

    c_edge_pulse: cover property (edge_mode && s_reg.st == SHP_PULSE ##1 s_reg.st == SHP_HOLD);
    c_level_low: cover property (!edge_mode && !active_high && pending ##1 !irq_out);

endmodule

// File: rtl/srcirq_status.sv
// Interrupt source and pin event status, enable masks and control register
`timescale 1ns/1ps
`include "srcirq_cfg.svh"

module srcirq_status
    import srcirq_pkg::*;
#(
    parameter int PULSE_CYC = `SRCIRQ_PULSE_CYC
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Register access
    input  srcirq_bus_s      bus,
    output logic [7:0]       reg_rdata,
    // Event pulses
    input  srcirq_evt_s      src_evt,
    input  wire logic [15:0] pin_evt,
    // Host interrupt pin
    output logic             irq_out
);

    srcirq_state_s s_reg;
    srcirq_state_s s_next;
    logic [7:0]    word_addr;
    logic          hi_byte;
    logic [15:0]   wr_val;
    logic [15:0]   wr_msk;
    logic [15:0]   rd_word;
    logic [8:0]    src_set;
    logic [8:0]    src_clr;
    logic [15:0]   pin_clr;
    logic          pin_live;
    logic          pending;

    // ---------------------------------------------------------------
    // Byte addressing
    // ---------------------------------------------------------------
    // High byte sits at the even address
    always_comb
    begin
        word_addr = {bus.addr[7:1], 1'b0};
        hi_byte   = ~bus.addr[0];
        wr_val    = hi_byte ? {bus.wdata, 8'h00} : {8'h00, bus.wdata};
        wr_msk    = hi_byte ? 16'hff00 : 16'h00ff;
    end

    // ---------------------------------------------------------------
    // Register next state
    // ---------------------------------------------------------------
    // Set wins over a clear arriving in the same cycle
    always_comb
    begin
        s_next  = s_reg;
        src_set = 9'h000;
        src_set[`SRCIRQ_SRC_WAKE_BIT] = src_evt.wake;
        src_set[`SRCIRQ_SRC_KP_BIT]   = src_evt.kp;
        src_set[`SRCIRQ_SRC_OVF_BIT]  = src_evt.kp_ovf;
        src_set[`SRCIRQ_SRC_PWM_LSB +: 4] = src_evt.pwm;
        src_set[`SRCIRQ_SRC_GPIO_BIT] = |pin_evt;
        src_clr = 9'h000;
        pin_clr = 16'h0000;
        if (bus.wr)
        begin
            unique case (word_addr)
                `SRCIRQ_CTRL_ADDR:
                    s_next.ctrl = (s_reg.ctrl & ~wr_msk[2:0]) | (wr_val[2:0] & wr_msk[2:0]);
                `SRCIRQ_SRC_EN_ADDR:
                    s_next.src_en = (s_reg.src_en & ~wr_msk[8:0]) | (wr_val[8:0] & wr_msk[8:0]);
                `SRCIRQ_SRC_STA_ADDR:
                    src_clr = wr_val[8:0];
                `SRCIRQ_PIN_EN_ADDR:
                    s_next.pin_en = (s_reg.pin_en & ~wr_msk) | (wr_val & wr_msk);
                `SRCIRQ_PIN_STA_ADDR:
                    pin_clr = wr_val;
                default:
                    s_next.ctrl = s_reg.ctrl;
            endcase
        end
        // Reserved source bit 3 never holds a one
        s_next.src_en[`SRCIRQ_SRC_RSVD_BIT] = 1'b0;
        s_next.src_sta = (s_reg.src_sta & ~src_clr) | src_set;
        s_next.pin_sta = (s_reg.pin_sta & ~pin_clr) | pin_evt;
        // Read data, unmapped addresses read zero
        unique case (word_addr)
            `SRCIRQ_CTRL_ADDR:    rd_word = {13'h0000, s_reg.ctrl};
            `SRCIRQ_SRC_EN_ADDR:  rd_word = {7'h00, s_reg.src_en};
            `SRCIRQ_SRC_STA_ADDR: rd_word = {7'h00, s_reg.src_sta};
            `SRCIRQ_PIN_EN_ADDR:  rd_word = s_reg.pin_en;
            `SRCIRQ_PIN_STA_ADDR: rd_word = s_reg.pin_sta;
            default:              rd_word = 16'h0000;
        endcase
        if (bus.rd)
        begin
            s_next.rdata = hi_byte ? rd_word[15:8] : rd_word[7:0];
        end
    end

    // Register state
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_reg.ctrl    <= `SRCIRQ_CTRL_RST;
            s_reg.src_en  <= `SRCIRQ_SRC_RST;
            s_reg.src_sta <= `SRCIRQ_SRC_RST;
            s_reg.pin_en  <= `SRCIRQ_PIN_RST;
            s_reg.pin_sta <= `SRCIRQ_PIN_RST;
            s_reg.rdata   <= 8'h00;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // Interrupt request
    // ---------------------------------------------------------------
    // Bit 8 counts only while an enabled pin is pending, so a pin mask
    // of zero keeps a pin event off the output even with bit 8 enabled
    always_comb
    begin
        pin_live = |(s_reg.pin_sta & s_reg.pin_en);
        pending  = s_reg.ctrl[`SRCIRQ_CTRL_GATE_BIT]
                 & (|(s_reg.src_sta[7:0] & s_reg.src_en[7:0])
                 | (s_reg.src_sta[8] & s_reg.src_en[8] & pin_live));
    end

    srcirq_shaper #(
        .PULSE_CYC  (PULSE_CYC)
    ) u_shaper (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .pending     (pending),
        .edge_mode   (s_reg.ctrl[`SRCIRQ_CTRL_TYPE_BIT]),
        .active_high (s_reg.ctrl[`SRCIRQ_CTRL_POL_BIT]),
        .irq_out     (irq_out)
    );

    assign reg_rdata = s_reg.rdata;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_gate_en;
        pending |-> s_reg.ctrl[0] && (|(s_reg.src_sta & s_reg.src_en));
    endproperty
    a_gate_en: assert property (p_gate_en) else $error("pending without enable");

    property p_wake_set;
        src_evt.wake |=> s_reg.src_sta[0];
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake flag lost");

    property p_pwm_map;
        src_evt.pwm[3] |=> s_reg.src_sta[7];
    endproperty
    a_pwm_map: assert property (p_pwm_map) else $error("pwm3 not on bit 7");

    property p_gpio_sum;
        pin_evt[5] |=> s_reg.src_sta[8] && s_reg.pin_sta[5];
    endproperty
    a_gpio_sum: assert property (p_gpio_sum) else $error("pin event not summarised");

    property p_src_clr;
        (bus.wr && bus.addr == 8'h15 && bus.wdata[1] && !src_evt.kp) |=> !s_reg.src_sta[1];
    endproperty
    a_src_clr: assert property (p_src_clr) else $error("source clear failed");

    property p_src_keep;
        (bus.wr && bus.addr == 8'h15 && !bus.wdata[2] && s_reg.src_sta[2]) |=> s_reg.src_sta[2];
    endproperty
    a_src_keep: assert property (p_src_keep) else $error("source bit lost");

    property p_pin_clr;
        (bus.wr && bus.addr == 8'h18 && bus.wdata[0] && !pin_evt[8]) |=> !s_reg.pin_sta[8];
    endproperty
    a_pin_clr: assert property (p_pin_clr) else $error("pin clear failed");

    property p_pin_rec;
        (pin_evt[3] && !s_reg.pin_en[3]) |=> s_reg.pin_sta[3];
    endproperty
    a_pin_rec: assert property (p_pin_rec) else $error("masked pin not recorded");

    property p_rsvd_zero;
        (bus.rd && bus.addr == 8'h12) |=> reg_rdata[7:1] == 7'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

    property p_gate_off;
        !s_reg.ctrl[0] |-> !pending;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate ignored");

    c_src_irq: cover property (src_evt.kp ##[1:10] pending);
    c_pin_irq: cover property (pin_evt[0] ##[1:10] (pending && s_reg.src_sta[8]));
    c_clear: cover property (pending ##[1:20] !pending);

endmodule

// File: test/srcirq_host.sv
// Host side model: byte register cycles toward the interrupt block
`timescale 1ns/1ps

module srcirq_host
    import srcirq_pkg::*;
(
    // Clock and read data
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    // Register access
    output srcirq_bus_s     bus
);
    initial bus = '0;

    // One byte write; lines show the inverse once released so stale data never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // One byte read; data taken one edge after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        #1 d = reg_rdata;
    endtask

    // Pin acknowledge needs both the pin flag and the summary flag cleared
    task automatic ack_pin(input logic [7:0] a, input logic [7:0] m);
        wr(a, m);
        wr(8'h14, 8'h01);
    endtask
endmodule

// File: test/testbench.sv
// Self-checking bench for the interrupt source and pin status block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end

module testbench;
    import srcirq_pkg::*;
    localparam int PULSE = 4; // Short pulse keeps the run brief
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    srcirq_bus_s bus;
    logic [7:0]  reg_rdata;
    srcirq_evt_s src_evt = '0;
    logic [15:0] pin_evt = 16'h0000;
    logic        irq_out;
    int          fails   = 0;
    int          checks  = 0;
    logic [7:0]  d;

    // ---------------------------------------------------------------
    // Clock, design and host model
    // ---------------------------------------------------------------
    always #2.5 sys_clk = ~sys_clk;

    srcirq_status #(.PULSE_CYC(PULSE)) i_srcirq_status (
        .sys_clk(sys_clk), .rst(rst), .bus(bus), .reg_rdata(reg_rdata),
        .src_evt(src_evt), .pin_evt(pin_evt), .irq_out(irq_out));
    srcirq_host i_srcirq_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .bus(bus));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        i_srcirq_host.rd(a, d);
        `CHK(d, e)
    endtask

    // One-cycle event pulse, then time for the flag to land
    task automatic fire(input logic [6:0] s, input logic [15:0] p);
        @(posedge sys_clk);
        src_evt <= s;
        pin_evt <= p;
        @(posedge sys_clk);
        src_evt <= '0;
        pin_evt <= 16'h0000;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        for (int a = 8'h10; a <= 8'h19; a++) rchk(8'(a), 8'h00);
        rchk(8'h1a, 8'h00);
        `CHK(irq_out, 1'b1)
    endtask

    // Flags set with all enables clear; zero writes keep, one writes clear
    task automatic t_flags;
        logic [7:0] e;
        for (int i = 0; i < 7; i++)
        begin
            e = (i < 3) ? 8'(1 << i) : 8'(1 << (i + 1));
            fire(7'(1 << i), 16'h0000);
            rchk(8'h15, e);
            i_srcirq_host.wr(8'h15, ~e);
            rchk(8'h15, e);
            i_srcirq_host.wr(8'h15, e);
            rchk(8'h15, 8'h00);
        end
        // Pins 15, 8 and 5: both bytes hold a flag, bit 0 of the high byte too
        fire(7'h00, 16'h8120);
        rchk(8'h18, 8'h81);
        rchk(8'h19, 8'h20);
        rchk(8'h14, 8'h01);
        i_srcirq_host.wr(8'h19, 8'h20);
        rchk(8'h18, 8'h81);
        rchk(8'h19, 8'h00);
        i_srcirq_host.ack_pin(8'h18, 8'h81);
        rchk(8'h18, 8'h00);
        rchk(8'h14, 8'h00);
    endtask

    task automatic t_reserved;
        i_srcirq_host.wr(8'h12, 8'hff);
        i_srcirq_host.wr(8'h13, 8'hff);
        rchk(8'h12, 8'h01);
        rchk(8'h13, 8'hf7);
        i_srcirq_host.wr(8'h16, 8'ha5);
        rchk(8'h16, 8'ha5);
        i_srcirq_host.wr(8'h12, 8'h00);
        i_srcirq_host.wr(8'h13, 8'h01);
        i_srcirq_host.wr(8'h16, 8'h00);
    endtask

    // Level mode: gate, mask, hold until cleared, polarity
    task automatic t_level;
        i_srcirq_host.wr(8'h11, 8'h05);
        rchk(8'h11, 8'h05);
        fire(7'h01, 16'h0000);
        `CHK(irq_out, 1'b1)
        repeat (6) @(posedge sys_clk);
        #1 `CHK(irq_out, 1'b1)
        i_srcirq_host.wr(8'h15, 8'h01);
        #6 `CHK(irq_out, 1'b0)
        fire(7'h02, 16'h0000);
        `CHK(irq_out, 1'b0)
        i_srcirq_host.wr(8'h15, 8'h02);
        i_srcirq_host.wr(8'h11, 8'h04);
        fire(7'h01, 16'h0000);
        `CHK(irq_out, 1'b0)
        i_srcirq_host.wr(8'h11, 8'h01);
        #6 `CHK(irq_out, 1'b0)
        i_srcirq_host.wr(8'h15, 8'h01);
        #6 `CHK(irq_out, 1'b1)
    endtask

    // Edge mode through the pin path: one fixed pulse, masked pin silent
    task automatic t_edge;
        int n;
        i_srcirq_host.wr(8'h13, 8'h00);
        i_srcirq_host.wr(8'h12, 8'h01);
        i_srcirq_host.wr(8'h19, 8'h04);
        i_srcirq_host.wr(8'h17, 8'h04);
        i_srcirq_host.wr(8'h11, 8'h07);
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            @(posedge sys_clk);
            pin_evt <= 16'(4 << k);
            @(posedge sys_clk);
            pin_evt <= 16'h0000;
            repeat (PULSE + 8)
            begin
                @(posedge sys_clk);
                // Active high here; an unknown level counts as active
                #1 n += (irq_out !== 1'b0);
            end
            `CHK(n, (k == 0) ? PULSE : 0)
            i_srcirq_host.ack_pin(8'h19, 8'(4 << k));
            rchk(8'h14, 8'h00);
        end
    endtask

    // ---------------------------------------------------------------
    // Verdict and run control
    // ---------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run is a few hundred cycles; this limit leaves wide margin
    initial
    begin
        #100000;
        fails++;
        conclude();
    end

    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_flags();
        t_reserved();
        t_level();
        t_edge();
        // Reset again mid-run: registers and the pin fall back to reset values
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        conclude();
    end
endmodule
